// >>> core/dma_hdr_pkg.sv
package dma_hdr_pkg;
    // Link request geometry: byte offset inside one BAR, 32 KByte window
    localparam int ADDR_W = 15;
    localparam int MEM_WORDS = 8192;
    localparam int DATA_W = 32;
    // BAR numbers as presented on the link; the 64-bit control pair answers to either number
    localparam logic [2:0] BAR_CTRL_LO = 3'h2;
    localparam logic [2:0] BAR_CTRL_HI = 3'h3;
    localparam logic [2:0] BAR_LAST = 3'h5;
    // Header block: two headers of four words, 256-byte decode
    localparam int HDR_SEL_BIT = 4;
    localparam int CTRL_SPAN_LSB = 8;
    localparam logic [1:0] HDR_CTRL = 2'h0;
    localparam logic [1:0] HDR_BASE_HI = 2'h1;
    localparam logic [1:0] HDR_BASE_LO = 2'h2;
    localparam logic [1:0] HDR_READY = 2'h3;
    localparam logic HDR_WRITE = 1'b0;
    localparam logic HDR_READ = 1'b1;
    // Control word fields
    localparam int SIZE_MSB = 15;
    localparam int DIR_BIT = 16;
    localparam int MSI_BIT = 17;
    localparam int REPORT_BIT = 18;
    localparam int NUM_LSB = 20;
    localparam int NUM_MSB = 24;
    localparam int TC_LSB = 28;
    localparam int TC_MSB = 30;
    localparam logic [31:0] CTRL_WMASK = 32'h71f7ffff;
    localparam logic [31:0] READY_WMASK = 32'h0000ffff;
    localparam logic [31:0] WR_CTRL_RESET = 32'h00110000;
    localparam logic [31:0] RD_CTRL_RESET = 32'h00000000;
    localparam int DESC_SHIFT = 4;
    // Host command registers, AXI4-Lite byte offsets
    localparam logic [4:0] CMD_ADDR_OFS = 5'h00;
    localparam logic [4:0] CMD_WDATA_OFS = 5'h04;
    localparam logic [4:0] CMD_CTRL_OFS = 5'h08;
    localparam logic [4:0] CMD_STATUS_OFS = 5'h0c;
    localparam logic [4:0] CMD_RDATA_OFS = 5'h10;
    localparam logic [4:0] IRQ_STATUS_OFS = 5'h14;
    localparam logic [4:0] IRQ_MASK_OFS = 5'h18;
    localparam int CMD_BAR_LSB = 16;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_WRITE_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_REFUSED_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_REQ = 3'b010,
        H_WAIT = 3'b100
    } host_state_type;
endpackage : dma_hdr_pkg

// >>> core/pcie_link_if.sv
`timescale 1ns/100ps
// Memory request path from root complex to endpoint, plus read completion
interface pcie_link_if;
    logic req_valid;
    logic req_ready;
    logic req_write;
    logic [2:0] req_bar;
    logic [dma_hdr_pkg::ADDR_W-1:0] req_addr;
    logic [31:0] req_wdata;
    logic cpl_valid;
    logic [31:0] cpl_data;
    modport host(output req_valid, req_write, req_bar, req_addr, req_wdata,
                 input req_ready, cpl_valid, cpl_data);
    modport device(input req_valid, req_write, req_bar, req_addr, req_wdata,
                   output req_ready, cpl_valid, cpl_data);
endinterface : pcie_link_if

// >>> core/dma_endpoint.sv
`timescale 1ns/100ps
module dma_endpoint (
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    pcie_link_if.device link,
    input wire logic FETCH_READY_I,
    output logic FETCH_VALID_O,
    output logic FETCH_SEL_O,
    output logic FETCH_DIR_O,
    output logic [63:0] FETCH_ADDR_O,
    output logic [15:0] FETCH_INDEX_O,
    input wire logic DESC_DONE_I,
    input wire logic DESC_DONE_SEL_I,
    input wire logic DESC_MSI_I,
    input wire logic DESC_REPORT_I,
    output logic MSI_REQ_O,
    output logic [4:0] MSI_NUM_O,
    output logic [2:0] MSI_TC_O,
    output logic REPORT_REQ_O,
    output logic REPORT_SEL_O,
    output logic [15:0] REPORT_COUNT_O
);
    import dma_hdr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Storage
    logic [31:0] mem [MEM_WORDS];
    logic [31:0] hdr_reg [2][4];
    logic [15:0] fetch_idx_reg [2];
    logic [15:0] done_cnt_reg [2];
    logic req_ready_reg;
    logic cpl_valid_reg;
    logic [31:0] cpl_data_reg;
    logic fetch_valid_reg;
    logic fetch_sel_reg;
    logic fetch_dir_reg;
    logic [63:0] fetch_addr_reg;
    logic [15:0] fetch_index_reg;
    logic msi_req_reg;
    logic [4:0] msi_num_reg;
    logic [2:0] msi_tc_reg;
    logic report_req_reg;
    logic report_sel_reg;
    logic [15:0] report_count_reg;

    ////////////////////////////////////////////////////////////////////////
    // Request decode
    logic take;
    logic is_ctrl;
    logic is_mem;
    logic in_span;
    logic hsel;
    logic [1:0] dsel;
    logic [12:0] word;
    logic [1:0] restart;
    logic [1:0] can_fetch;

    assign take = link.req_valid && req_ready_reg;
    assign is_ctrl = (link.req_bar == BAR_CTRL_LO) || (link.req_bar == BAR_CTRL_HI);
    assign is_mem = (link.req_bar <= BAR_LAST) && !is_ctrl;
    // Only the first 256 bytes of the control BAR decode
    assign in_span = (link.req_addr[ADDR_W-1:CTRL_SPAN_LSB] == '0);
    assign hsel = link.req_addr[HDR_SEL_BIT];
    assign dsel = link.req_addr[3:2];
    assign word = link.req_addr[ADDR_W-1:2];
    assign link.req_ready = req_ready_reg;
    assign link.cpl_valid = cpl_valid_reg;
    assign link.cpl_data = cpl_data_reg;

    // Link is always open once out of reset; no back-pressure needed
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            req_ready_reg <= 1'b0;
        end else begin
            req_ready_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Target memory, bypasses the engine; no reset on the array
    always_ff @(posedge REF_CLK_I) begin
        if (take && link.req_write && is_mem) begin
            mem[word] <= link.req_wdata;
        end
    end

    // Read completion one cycle after the request is taken
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cpl_valid_reg <= 1'b0;
            cpl_data_reg <= 32'h00000000;
        end else begin
            cpl_valid_reg <= take && !link.req_write;
            if (take && !link.req_write) begin
                if (is_mem) begin
                    cpl_data_reg <= mem[word];
                end else if (is_ctrl && in_span && !link.req_addr[HDR_SEL_BIT+1]) begin
                    cpl_data_reg <= hdr_reg[hsel][dsel];
                end else begin
                    // ROM and I/O BARs are not served; answer zero
                    cpl_data_reg <= 32'h00000000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Header registers
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            for (int h = 0; h < 2; h++) begin
                for (int d = 0; d < 4; d++) begin
                    hdr_reg[h][d] <= 32'h00000000;
                end
            end
            hdr_reg[HDR_WRITE][HDR_CTRL] <= WR_CTRL_RESET;
            hdr_reg[HDR_READ][HDR_CTRL] <= RD_CTRL_RESET;
        end else if (take && link.req_write && is_ctrl && in_span && !link.req_addr[HDR_SEL_BIT+1]) begin
            if (dsel == HDR_CTRL) begin
                hdr_reg[hsel][dsel] <= link.req_wdata & CTRL_WMASK;
            end else if (dsel == HDR_READY) begin
                // Software may bump this at any time
                hdr_reg[hsel][dsel] <= link.req_wdata & READY_WMASK;
            end else begin
                hdr_reg[hsel][dsel] <= link.req_wdata;
            end
        end
    end

    // A new control word starts that header's table over
    always_comb begin
        restart = 2'b00;
        if (take && link.req_write && is_ctrl && in_span && !link.req_addr[HDR_SEL_BIT+1]
            && dsel == HDR_CTRL) begin
            restart[hsel] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Descriptor fetch
    // Bounded by both table size and the ready count
    always_comb begin
        for (int h = 0; h < 2; h++) begin
            can_fetch[h] = (fetch_idx_reg[h] < hdr_reg[h][HDR_CTRL][SIZE_MSB:0])
                && (fetch_idx_reg[h] < hdr_reg[h][HDR_READY][15:0])
                && !restart[h];
        end
    end

    // Write header has priority; read header fetches when write has none
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            fetch_valid_reg <= 1'b0;
            fetch_sel_reg <= 1'b0;
            fetch_dir_reg <= 1'b0;
            fetch_addr_reg <= 64'h0000000000000000;
            fetch_index_reg <= 16'h0000;
            fetch_idx_reg[0] <= 16'h0000;
            fetch_idx_reg[1] <= 16'h0000;
        end else begin
            if (!fetch_valid_reg || FETCH_READY_I) begin
                fetch_valid_reg <= 1'b0;
                for (int h = 1; h >= 0; h--) begin
                    if (can_fetch[h]) begin
                        fetch_valid_reg <= 1'b1;
                        fetch_sel_reg <= h[0];
                        fetch_dir_reg <= hdr_reg[h][HDR_CTRL][DIR_BIT];
                        // Descriptors follow the header, four words each
                        fetch_addr_reg <= {hdr_reg[h][HDR_BASE_HI], hdr_reg[h][HDR_BASE_LO]}
                            + ({48'h000000000000, fetch_idx_reg[h]} + 64'h1) * (64'h1 << DESC_SHIFT);
                        fetch_index_reg <= fetch_idx_reg[h];
                    end
                end
                if (can_fetch[0]) begin
                    fetch_idx_reg[0] <= fetch_idx_reg[0] + 16'h0001;
                end else if (can_fetch[1]) begin
                    fetch_idx_reg[1] <= fetch_idx_reg[1] + 16'h0001;
                end
            end
            for (int h = 0; h < 2; h++) begin
                if (restart[h]) begin
                    fetch_idx_reg[h] <= 16'h0000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-descriptor completion: interrupt and count report
    logic [31:0] done_ctrl;
    assign done_ctrl = hdr_reg[DESC_DONE_SEL_I][HDR_CTRL];

    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            msi_req_reg <= 1'b0;
            msi_num_reg <= 5'h00;
            msi_tc_reg <= 3'h0;
            report_req_reg <= 1'b0;
            report_sel_reg <= 1'b0;
            report_count_reg <= 16'h0000;
            done_cnt_reg[0] <= 16'h0000;
            done_cnt_reg[1] <= 16'h0000;
        end else begin
            msi_req_reg <= 1'b0;
            report_req_reg <= 1'b0;
            if (DESC_DONE_I) begin
                msi_req_reg <= done_ctrl[MSI_BIT] | DESC_MSI_I;
                msi_num_reg <= done_ctrl[NUM_MSB:NUM_LSB];
                msi_tc_reg <= done_ctrl[TC_MSB:TC_LSB];
                report_req_reg <= done_ctrl[REPORT_BIT] | DESC_REPORT_I;
                report_sel_reg <= DESC_DONE_SEL_I;
                // Last completed descriptor, counted from zero
                report_count_reg <= done_cnt_reg[DESC_DONE_SEL_I];
                done_cnt_reg[DESC_DONE_SEL_I] <= done_cnt_reg[DESC_DONE_SEL_I] + 16'h0001;
            end
            for (int h = 0; h < 2; h++) begin
                if (restart[h]) begin
                    done_cnt_reg[h] <= 16'h0000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign FETCH_VALID_O = fetch_valid_reg;
    assign FETCH_SEL_O = fetch_sel_reg;
    assign FETCH_DIR_O = fetch_dir_reg;
    assign FETCH_ADDR_O = fetch_addr_reg;
    assign FETCH_INDEX_O = fetch_index_reg;
    assign MSI_REQ_O = msi_req_reg;
    assign MSI_NUM_O = msi_num_reg;
    assign MSI_TC_O = msi_tc_reg;
    assign REPORT_REQ_O = report_req_reg;
    assign REPORT_SEL_O = report_sel_reg;
    assign REPORT_COUNT_O = report_count_reg;
endmodule : dma_endpoint

// >>> core/root_requester.sv
`timescale 1ns/100ps
module root_requester (
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    pcie_link_if.host link,
    input wire logic [4:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [4:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    output logic IRQ_O
);
    import dma_hdr_pkg::*;

    logic awready_reg, wready_reg, aw_held, w_held, bvalid_reg, arready_reg, rvalid_reg, irq_reg;
    logic [4:0] awaddr_reg;
    logic [31:0] wdata_reg, rdata_reg, cmd_addr_reg, cmd_wdata_reg, cpl_reg;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg, rresp_reg, irq_status_reg, irq_mask_reg, events;
    host_state_type state_reg;
    logic req_valid_reg, req_write_reg;
    logic [2:0] req_bar_reg;
    logic [ADDR_W-1:0] req_addr_reg;
    logic [31:0] req_wdata_reg;
    logic aw_take, w_take, ar_take, do_write, go;

    // Byte-lane merge for software writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                old[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return old;
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write: address and data taken in either order
    assign aw_take = S_AXI_AWVALID_I && awready_reg;
    assign w_take = S_AXI_WVALID_I && wready_reg;
    assign do_write = aw_held && w_held && !bvalid_reg;
    assign go = do_write && awaddr_reg == CMD_CTRL_OFS && wstrb_reg[0] && wdata_reg[CTRL_GO_BIT];

    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            awaddr_reg <= 5'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else begin
            if (aw_take) begin
                awaddr_reg <= S_AXI_AWADDR_I;
            end
            if (w_take) begin
                wdata_reg <= S_AXI_WDATA_I;
                wstrb_reg <= S_AXI_WSTRB_I;
            end
            aw_held <= aw_take || (aw_held && !do_write);
            w_held <= w_take || (w_held && !do_write);
            awready_reg <= !(aw_take || (aw_held && !do_write));
            wready_reg <= !(w_take || (w_held && !do_write));
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= (awaddr_reg > IRQ_MASK_OFS || awaddr_reg[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
            end else if (S_AXI_BREADY_I) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Command and mask registers; status clears by writing one, set wins
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cmd_addr_reg <= 32'h00000000;
            cmd_wdata_reg <= 32'h00000000;
            irq_mask_reg <= 2'h0;
            irq_status_reg <= 2'h0;
            irq_reg <= 1'b0;
        end else begin
            if (do_write && awaddr_reg == CMD_ADDR_OFS) begin
                cmd_addr_reg <= merge(cmd_addr_reg, wdata_reg, wstrb_reg);
            end
            if (do_write && awaddr_reg == CMD_WDATA_OFS) begin
                cmd_wdata_reg <= merge(cmd_wdata_reg, wdata_reg, wstrb_reg);
            end
            if (do_write && awaddr_reg == IRQ_MASK_OFS && wstrb_reg[0]) begin
                irq_mask_reg <= wdata_reg[1:0];
            end
            if (do_write && awaddr_reg == IRQ_STATUS_OFS && wstrb_reg[0]) begin
                irq_status_reg <= (irq_status_reg & ~wdata_reg[1:0]) | events;
            end else begin
                irq_status_reg <= irq_status_reg | events;
            end
            irq_reg <= |(irq_status_reg & irq_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read
    assign ar_take = S_AXI_ARVALID_I && arready_reg;

    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= RESP_OKAY;
        end else begin
            arready_reg <= !(ar_take || (rvalid_reg && !S_AXI_RREADY_I));
            if (ar_take) begin
                rvalid_reg <= 1'b1;
                rresp_reg <= RESP_OKAY;
                if (S_AXI_ARADDR_I == CMD_ADDR_OFS) begin
                    rdata_reg <= cmd_addr_reg;
                end else if (S_AXI_ARADDR_I == CMD_WDATA_OFS) begin
                    rdata_reg <= cmd_wdata_reg;
                end else if (S_AXI_ARADDR_I == CMD_STATUS_OFS) begin
                    rdata_reg <= {31'h0, state_reg != H_IDLE};
                end else if (S_AXI_ARADDR_I == CMD_RDATA_OFS) begin
                    rdata_reg <= cpl_reg;
                end else if (S_AXI_ARADDR_I == IRQ_STATUS_OFS) begin
                    rdata_reg <= {30'h0, irq_status_reg};
                end else if (S_AXI_ARADDR_I == IRQ_MASK_OFS) begin
                    rdata_reg <= {30'h0, irq_mask_reg};
                end else begin
                    rdata_reg <= 32'h00000000;
                    rresp_reg <= (S_AXI_ARADDR_I == CMD_CTRL_OFS) ? RESP_OKAY : RESP_SLVERR;
                end
            end else if (S_AXI_RREADY_I) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link request sequencer; a go while busy is dropped
    always_comb begin
        events = 2'h0;
        if (state_reg == H_IDLE && go && cmd_addr_reg[CMD_BAR_LSB +: 3] > BAR_LAST) begin
            events[IRQ_REFUSED_BIT] = 1'b1;
        end
        if ((state_reg == H_REQ && link.req_ready && req_write_reg) || (state_reg == H_WAIT && link.cpl_valid)) begin
            events[IRQ_DONE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_reg <= H_IDLE;
            req_valid_reg <= 1'b0;
            req_write_reg <= 1'b0;
            req_bar_reg <= 3'h0;
            req_addr_reg <= '0;
            req_wdata_reg <= 32'h00000000;
            cpl_reg <= 32'h00000000;
        end else begin
            case (state_reg)
                H_IDLE: begin
                    // ROM and I/O BARs never reach the link
                    if (go && cmd_addr_reg[CMD_BAR_LSB +: 3] <= BAR_LAST) begin
                        req_valid_reg <= 1'b1;
                        req_write_reg <= wdata_reg[CTRL_WRITE_BIT];
                        req_bar_reg <= cmd_addr_reg[CMD_BAR_LSB +: 3];
                        req_addr_reg <= cmd_addr_reg[ADDR_W-1:0];
                        req_wdata_reg <= cmd_wdata_reg;
                        state_reg <= H_REQ;
                    end
                end
                H_REQ: begin
                    if (link.req_ready) begin
                        req_valid_reg <= 1'b0;
                        state_reg <= req_write_reg ? H_IDLE : H_WAIT;
                    end
                end
                H_WAIT: begin
                    if (link.cpl_valid) begin
                        cpl_reg <= link.cpl_data;
                        state_reg <= H_IDLE;
                    end
                end
                default: begin
                    state_reg <= H_IDLE;
                end
            endcase
        end
    end

    assign link.req_valid = req_valid_reg;
    assign link.req_write = req_write_reg;
    assign link.req_bar = req_bar_reg;
    assign link.req_addr = req_addr_reg;
    assign link.req_wdata = req_wdata_reg;
    assign S_AXI_AWREADY_O = awready_reg;
    assign S_AXI_WREADY_O = wready_reg;
    assign S_AXI_BRESP_O = bresp_reg;
    assign S_AXI_BVALID_O = bvalid_reg;
    assign S_AXI_ARREADY_O = arready_reg;
    assign S_AXI_RDATA_O = rdata_reg;
    assign S_AXI_RRESP_O = rresp_reg;
    assign S_AXI_RVALID_O = rvalid_reg;
    assign IRQ_O = irq_reg;
endmodule : root_requester

// >>> tb/link_asserts.sv
`timescale 1ns/100ps
// Watches the link between requester and endpoint
module link_asserts (
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_write,
    input wire logic [2:0] req_bar,
    input wire logic [dma_hdr_pkg::ADDR_W-1:0] req_addr,
    input wire logic [31:0] req_wdata,
    input wire logic cpl_valid,
    input wire logic [31:0] cpl_data
);
    import dma_hdr_pkg::*;
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!NRST_I);
    wire logic take = req_valid && req_ready;
    ////////////////////////////////////////////////////////////////////////
    // Request address only moves when a new request is offered
    a_req_held: assert property (!req_valid |=> req_valid || $stable(req_addr))
        else $error("request fields moved");
    a_read_answer: assert property (take && !req_write |=> cpl_valid)
        else $error("read without answer");
    a_write_posted: assert property (take && req_write |=> !cpl_valid)
        else $error("write answered");
    a_cpl_single: assert property (cpl_valid |=> !cpl_valid)
        else $error("answer too long");
    a_bar_legal: assert property (req_valid |-> req_bar <= BAR_LAST)
        else $error("bad bar sent");
    a_data_hold: assert property ($changed(cpl_data) |-> cpl_valid)
        else $error("answer data moved");
    a_ready_kept: assert property (req_ready |=> req_ready)
        else $error("ready dropped");
    a_req_gap: assert property (take |=> !req_valid)
        else $error("no gap");
    // Main traffic kinds
    cover property (take && req_write && req_bar == BAR_CTRL_LO);
    cover property (take && !req_write);
    cover property (take && req_bar == BAR_LAST);
endmodule : link_asserts

// >>> tb/test_chaining_dma_header_regs.sv
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
    $display("wrong value at %0t: got %0h want %0h", $time, (a), (e)); end end
module test_chaining_dma_header_regs;
    import dma_hdr_pkg::*;
    logic clk = 0, nrst = 0, awv = 0, wv = 0, arv = 0, frdy = 0, done = 0, drep = 0;
    logic [4:0] awa = 0, ara = 0, mnum;
    logic [31:0] wd = 0, rdv, base, r, rdata;
    logic [1:0] brv, bresp, rresp;
    logic awr, wrr, bv, arr, rv, irq, fv, fsel, msi, rep, rsel;
    logic [63:0] faddr, la, n;
    logic [2:0] mtc;
    logic ld, fdir;
    logic [15:0] fidx, rcnt, li;
    logic [63:0] q[$];
    int fails = 0, tests_run = 0, nf = 0, seed = 32'h6507;
    pcie_link_if pcie_link_if_i();
    root_requester root_requester_i (.REF_CLK_I(clk), .NRST_I(nrst), .link(pcie_link_if_i),
        .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
        .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrr), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(1'b1), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
        .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
        .S_AXI_RREADY_I(1'b1), .IRQ_O(irq));
    dma_endpoint dma_endpoint_i (.REF_CLK_I(clk), .NRST_I(nrst), .link(pcie_link_if_i),
        .FETCH_READY_I(frdy), .FETCH_VALID_O(fv), .FETCH_SEL_O(fsel), .FETCH_DIR_O(fdir),
        .FETCH_ADDR_O(faddr), .FETCH_INDEX_O(fidx), .DESC_DONE_I(done), .DESC_DONE_SEL_I(1'b0),
        .DESC_MSI_I(1'b0), .DESC_REPORT_I(drep), .MSI_REQ_O(msi), .MSI_NUM_O(mnum), .MSI_TC_O(mtc),
        .REPORT_REQ_O(rep), .REPORT_SEL_O(rsel), .REPORT_COUNT_O(rcnt));
    link_asserts link_asserts_i (.REF_CLK_I(clk), .NRST_I(nrst), .req_valid(pcie_link_if_i.req_valid),
        .req_ready(pcie_link_if_i.req_ready), .req_write(pcie_link_if_i.req_write),
        .req_bar(pcie_link_if_i.req_bar), .req_addr(pcie_link_if_i.req_addr),
        .req_wdata(pcie_link_if_i.req_wdata), .cpl_valid(pcie_link_if_i.cpl_valid),
        .cpl_data(pcie_link_if_i.cpl_data));
    ////////////////////////////////////////////////////////////////////////
    always #20 clk = ~clk;
    // Random fetch stalls keep the engine's hold logic busy
    always @(posedge clk) frdy <= 1'($random(seed));
    // Oldest note meets each read answer; mask zero means a poll
    always @(posedge clk) if (rv) begin
        n = q.pop_front();
        `CHK(rdata & n[63:32], n[31:0])
    end
    // Write-header fetches only; the read header may run on meanwhile
    always @(posedge clk) if (fv && frdy && !fsel) begin
        nf++;
        la = faddr;
        ld = fdir;
        li = fidx;
    end
    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        do begin @(posedge clk); if (awr) awv <= 0; if (wrr) wv <= 0; end while (!bv);
        brv = bresp;
    endtask : wr
    task rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk);
        ara <= a;
        arv <= 1;
        q.push_back({m, e});
        do @(posedge clk); while (!arr);
        arv <= 0;
        do @(posedge clk); while (!rv);
        rdv = rdata;
        brv = rresp;
    endtask : rd
    // One link request, polled until idle since link timing is not fixed
    task link(input logic [2:0] b, input logic [14:0] o, input logic [31:0] d, input logic w);
        wr(CMD_ADDR_OFS, {13'h0, b, 1'b0, o});
        wr(CMD_WDATA_OFS, d);
        wr(CMD_CTRL_OFS, {30'h0, w, 1'b1});
        do rd(CMD_STATUS_OFS, 0, 0); while (rdv[STAT_BUSY_BIT]);
    endtask : link
    task lchk(input logic [2:0] b, input logic [14:0] o, input logic [31:0] e);
        link(b, o, 0, 0);
        rd(CMD_RDATA_OFS, e, '1);
    endtask : lchk
    task complete_run;
        $display("fails %0d tests_run %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        complete_run;
    end
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1;
        base = $random(seed) & 32'h7ff0;
        r = $random(seed);
        lchk(3'h2, 15'h00, 32'h00110000);
        lchk(3'h3, 15'h10, 32'h0);
        link(3'h3, 15'h10, '1, 1);
        lchk(3'h2, 15'h10, 32'h71f7ffff);
        link(3'h3, 15'h14, r, 1);
        lchk(3'h2, 15'h14, r);
        link(3'h2, 15'h1c, '1, 1);
        lchk(3'h3, 15'h1c, 32'h0000ffff);
        lchk(3'h3, 15'h20, 32'h0);
        link(3'h0, base[14:0], r, 1);
        lchk(3'h5, base[14:0], r);
        link(3'h4, base[14:0], ~r, 1);
        lchk(3'h1, base[14:0], ~r);
        wr(IRQ_MASK_OFS, 32'h2);
        link(3'h6, 15'h0, 0, 1);
        rd(IRQ_MASK_OFS, 32'h2, '1);
        `CHK(irq, 1'b1)
        wr(IRQ_STATUS_OFS, 32'h2);
        rd(IRQ_STATUS_OFS, 0, 32'h2);
        `CHK(irq, 1'b0)
        wr(5'h1c, 0);
        `CHK(brv, RESP_SLVERR)
        rd(5'h1c, 0, '1);
        `CHK(brv, RESP_SLVERR)
        link(3'h2, 15'h08, base, 1);
        link(3'h2, 15'h0c, 1, 1);
        link(3'h2, 15'h00, 32'h00130002, 1);
        repeat (40) @(posedge clk);
        `CHK(nf, 1)
        `CHK(la, {32'h0, base} + 64'h10)
        link(3'h2, 15'h0c, 2, 1);
        repeat (40) @(posedge clk);
        `CHK(nf, 2)
        `CHK(la, {32'h0, base} + 64'h20)
        `CHK({ld, li}, {1'b1, 16'h0001})
        done <= 1;
        drep <= 1;
        @(posedge clk);
        done <= 0;
        #1 `CHK({msi, mnum, mtc, rep, rsel}, {1'b1, 5'h1, 3'h0, 1'b1, 1'b0})
        `CHK(rcnt, 16'h0000)
        complete_run;
    end
endmodule : test_chaining_dma_header_regs
